// >>> inc/isq_pkg.sv
package isq_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned ENTRY_CYCLES = 11;
  localparam logic [3:0]  ENTRY_LAST   = 4'(ENTRY_CYCLES - 1);

  // ---------------------------------------------------------------
  // Timer control bit positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned TCR_REQ_BIT  = 7;
  localparam int unsigned TCR_MASK_BIT = 6;
  localparam logic        REQ_RESET    = 1'b0;
  localparam logic        MASK_RESET   = 1'b1;

  // ---------------------------------------------------------------
  // Vector addresses (defaults, 11-bit program space)
  // ---------------------------------------------------------------
  localparam logic [10:0] VEC_TIMER = 11'h7f8;
  localparam logic [10:0] VEC_EXT   = 11'h7fa;
  localparam logic [10:0] VEC_SOFT  = 11'h7fc;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ISQ_SRC_NONE  = 2'b00,
    ISQ_SRC_EXT   = 2'b01,
    ISQ_SRC_TIMER = 2'b10,
    ISQ_SRC_SOFT  = 2'b11
  } isq_src_e;

  typedef enum logic [1:0] {
    ISQ_RUN   = 2'b00,
    ISQ_ENTRY = 2'b01,
    ISQ_RET   = 2'b10
  } isq_state_e;

  // Core status presented at each instruction boundary
  typedef struct packed {
    logic instr_done;
    logic soft_trap_instr;
    logic return_from_irq_instr;
    logic cc_mask;
  } isq_core_s;

  // Entry sequence outputs to the core
  typedef struct packed {
    logic        stack_push;
    logic        set_mask;
    logic        vec_load;
    logic [10:0] vec_addr;
  } isq_entry_s;

endpackage : isq_pkg

// >>> verilog/isq_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Accepts external pin, timer request and software trap as interrupt sources.
// - Lets the current instruction, even a trap, finish before entry starts.
// - Pushes the complete CPU register state onto the stack on entry.
// - Sets the condition code interrupt mask bit during entry.
// - Loads the start address from the source's vector, then runs the routine.
// - Stacking, mask setting and vector fetch take exactly eleven cycles.
// - Return-from-interrupt restores stacked state and resumes the program.
// - Hardware requests never abort an instruction; they stay pending.
// - At each boundary, a trap or unmasked pending request starts entry; else a return unstacks, else next fetch.
// - Masked requests stay latched until the mask permits service.
// - External request wins over timer request at the same boundary.
// - Software trap always enters, whatever the mask bit.
// - External pin is synchronised; each falling edge latches a request.
// - Edge logic re-arms only after seeing the opposite level.
// - External pin level is readable by conditional branch logic.
// - Timer request flag sets on counter reaching zero; reset or software clears.
// - Timer mask bit blocks the timer request; reset sets it.
module isq_sequencer (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 irq_n_pin,
  input  wire logic                 timer_zero,
  input  wire logic                 tcr_wr,
  input  wire logic [7:0]           tcr_wdata,
  input  wire isq_pkg::isq_core_s   core,
  output var  isq_pkg::isq_entry_s  entry,
  output logic                      unstack,
  output logic                      fetch_next,
  output logic                      busy,
  output logic [1:0]                src_taken,
  output logic                      irq_pin_level,
  output logic                      timer_req_flag,
  output logic                      timer_req_mask
);

  // ---------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic [2:0] pin_sync_q;
  logic       pin_level_q;
  logic       ext_pend_q;
  logic       pin_agree;
  logic       pin_fall;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_sync_q <= 3'h7;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], irq_n_pin};
    end
  end

  // Stage 0 feeds only stage 1; stages 1 and 2 must agree before a change counts
  assign pin_agree = (pin_sync_q[1] == pin_sync_q[2]);
  // Re-arm: a fall only counts once the filtered level was high
  assign pin_fall  = pin_agree && !pin_sync_q[2] && pin_level_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_level_q <= 1'b1;
    end else if (pin_agree) begin
      pin_level_q <= pin_sync_q[2];
    end
  end

  assign irq_pin_level = pin_level_q;

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  isq_pkg::isq_state_e state_q;
  isq_pkg::isq_src_e   src_q;
  logic [3:0]          cnt_q;

  wire boundary   = (state_q == isq_pkg::ISQ_RUN) && core.instr_done;
  wire tmr_active = timer_req_flag && !timer_req_mask;
  wire hw_ok      = !core.cc_mask;
  wire take_soft  = boundary && core.soft_trap_instr;
  wire take_ext   = boundary && !core.soft_trap_instr && hw_ok && ext_pend_q;
  wire take_tmr   = boundary && !core.soft_trap_instr && hw_ok && !ext_pend_q
                    && tmr_active;
  wire take_any   = take_soft || take_ext || take_tmr;
  wire take_ret   = boundary && core.return_from_irq_instr && !core.soft_trap_instr;
  wire last_cnt   = (cnt_q == isq_pkg::ENTRY_LAST);

  isq_pkg::isq_src_e take_src;
  assign take_src = take_soft ? isq_pkg::ISQ_SRC_SOFT :
                    take_ext  ? isq_pkg::ISQ_SRC_EXT  :
                    take_tmr  ? isq_pkg::ISQ_SRC_TIMER : isq_pkg::ISQ_SRC_NONE;

  // ---------------------------------------------------------------
  // External request latch
  // ---------------------------------------------------------------
  // A new edge in the same cycle as service keeps the request pending
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_pend_q <= 1'b0;
    end else if (pin_fall) begin
      ext_pend_q <= 1'b1;
    end else if (take_ext) begin
      ext_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Timer control bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_req_flag <= isq_pkg::REQ_RESET;
      timer_req_mask <= isq_pkg::MASK_RESET;
    end else begin
      if (timer_zero) begin
        timer_req_flag <= 1'b1;
      end else if (tcr_wr) begin
        timer_req_flag <= tcr_wdata[isq_pkg::TCR_REQ_BIT];
      end
      if (tcr_wr) begin
        timer_req_mask <= tcr_wdata[isq_pkg::TCR_MASK_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Entry and return sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= isq_pkg::ISQ_RUN;
      src_q   <= isq_pkg::ISQ_SRC_NONE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        isq_pkg::ISQ_RUN: begin
          cnt_q <= 4'h0;
          if (take_any) begin
            state_q <= isq_pkg::ISQ_ENTRY;
            src_q   <= take_src;
          end else if (take_ret) begin
            state_q <= isq_pkg::ISQ_RET;
          end
        end
        isq_pkg::ISQ_ENTRY: begin
          cnt_q <= cnt_q + 4'h1;
          if (last_cnt) begin
            state_q <= isq_pkg::ISQ_RUN;
          end
        end
        isq_pkg::ISQ_RET: begin
          state_q <= isq_pkg::ISQ_RUN;
        end
        default: begin
          state_q <= isq_pkg::ISQ_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the core
  // ---------------------------------------------------------------
  wire in_entry = (state_q == isq_pkg::ISQ_ENTRY);

  // Push phase occupies the first five cycles: PC low, PC high, X, A, CC
  assign entry.stack_push = in_entry && (cnt_q < 4'h5);
  assign entry.set_mask   = in_entry && (cnt_q == 4'h5);
  assign entry.vec_load   = in_entry && last_cnt;
  assign entry.vec_addr   = (src_q == isq_pkg::ISQ_SRC_SOFT)  ? isq_pkg::VEC_SOFT :
                            (src_q == isq_pkg::ISQ_SRC_EXT)   ? isq_pkg::VEC_EXT  :
                            isq_pkg::VEC_TIMER;
  assign unstack    = (state_q == isq_pkg::ISQ_RET);
  assign fetch_next = boundary && !take_any && !take_ret;
  assign busy       = (state_q != isq_pkg::ISQ_RUN);
  assign src_taken  = src_q;

endmodule : isq_sequencer

`default_nettype wire

// >>> test/isq_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module isq_assertions (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire isq_pkg::isq_core_s  core,
  input wire isq_pkg::isq_entry_s entry,
  input wire logic                unstack,
  input wire logic                fetch_next,
  input wire logic                busy,
  input wire logic [1:0]          src_taken,
  input wire logic                timer_req_flag,
  input wire logic                timer_req_mask
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic bnd = core.instr_done & ~busy;
  wire logic hw  = ~core.soft_trap_instr & ~core.return_from_irq_instr;
  AST_TRAP: assert property (bnd && core.soft_trap_instr |=> busy && src_taken == 2'h3)
    else $error("trap not entered");
  AST_PUSH: assert property ($rose(entry.stack_push) |-> entry.stack_push [*5] ##1 entry.set_mask)
    else $error("push or mask step wrong");
  AST_LEN: assert property ($rose(entry.stack_push) |-> ##10 entry.vec_load ##1 !busy)
    else $error("entry length wrong");
  AST_VEC: assert property (entry.vec_load |-> entry.vec_addr == (src_taken == 2'h3 ?
    isq_pkg::VEC_SOFT : src_taken == 2'h1 ? isq_pkg::VEC_EXT : isq_pkg::VEC_TIMER))
    else $error("wrong vector");
  AST_HOLD: assert property (bnd && core.cc_mask && hw |-> fetch_next ##1 !busy)
    else $error("masked request entered");
  AST_FETCH: assert property (fetch_next |-> bnd)
    else $error("fetch off boundary");
  AST_RET: assert property (bnd && core.return_from_irq_instr && !core.soft_trap_instr
    |=> unstack ##1 !unstack)
    else $error("no unstack");
  AST_START: assert property ($rose(busy) |-> $past(bnd))
    else $error("entry off boundary");
  AST_RST: assert property (disable iff (1'b0) rst |=> timer_req_mask && !timer_req_flag)
    else $error("timer bits reset wrong");
endmodule : isq_assertions
`default_nettype wire

// >>> test/isq_irq_src.sv
`timescale 1ns/10ps
`default_nettype none
module isq_irq_src #(parameter int HOLD = 20) (
  input  wire logic clk_sys,
  output logic      irq_n_pin
);
  initial irq_n_pin = 1'b1;
  // Each level held 160 ns, so a full period stays above 266 ns
  task automatic drive(input logic lvl);
    irq_n_pin = lvl;
    repeat (HOLD) @(posedge clk_sys);
    #1;
  endtask : drive
endmodule : isq_irq_src
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  logic                timer_zero = 1'b0;
  logic                tcr_wr = 1'b0;
  logic [7:0]          tcr_wdata = 8'h00;
  isq_pkg::isq_core_s  core = '0;
  isq_pkg::isq_entry_s entry;
  logic                unstack, fetch_next, busy, lvl, flag, mask, fn;
  logic [1:0]          src_taken;
  wire logic           irq_n_pin;
  int                  num_errors = 0;
  int                  compares = 0;
  always #4 clk_sys = ~clk_sys;
  isq_irq_src i_isq_irq_src (.clk_sys(clk_sys), .irq_n_pin(irq_n_pin));
  isq_sequencer i_isq_sequencer (.clk_sys(clk_sys), .rst(rst), .irq_n_pin(irq_n_pin),
    .timer_zero(timer_zero), .tcr_wr(tcr_wr), .tcr_wdata(tcr_wdata), .core(core),
    .entry(entry), .unstack(unstack), .fetch_next(fetch_next), .busy(busy),
    .src_taken(src_taken), .irq_pin_level(lvl), .timer_req_flag(flag), .timer_req_mask(mask));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic bound(input logic trap, input logic ret);
    core.instr_done = 1'b1;
    core.soft_trap_instr = trap;
    core.return_from_irq_instr = ret;
    #1 fn = fetch_next;
    tick();
    core = '{1'b0, 1'b0, 1'b0, core.cc_mask};
  endtask : bound
  task automatic enter(input logic [1:0] src, input logic [10:0] vec);
    int n;
    logic [10:0] va;
    n = 0;
    va = '0;
    while (busy === 1'b1 && n < 20) begin
      if (entry.vec_load === 1'b1) va = entry.vec_addr;
      n++;
      tick();
    end
    check(11'(n), 11'(isq_pkg::ENTRY_CYCLES));
    check({9'h0, src_taken}, {9'h0, src});
    check(va, vec);
  endtask : enter
  task automatic tcr(input logic [7:0] d);
    tcr_wr = 1'b1;
    tcr_wdata = d;
    tick();
    tcr_wr = 1'b0;
  endtask : tcr
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_trap();
    check(11'({flag, mask, lvl, src_taken}), 11'h0c);
    core.cc_mask = 1'b1;
    bound(1'b1, 1'b0);
    enter(2'h3, isq_pkg::VEC_SOFT);
    bound(1'b0, 1'b1);
    check(11'({unstack, fn}), 11'h2);
    $display("t_trap done");
  endtask : t_trap
  task automatic t_hw();
    core.cc_mask = 1'b0;
    timer_zero = 1'b1;
    tick();
    timer_zero = 1'b0;
    bound(1'b0, 1'b0);
    check(11'({flag, fn, busy}), 11'h6);
    core.cc_mask = 1'b1;
    i_isq_irq_src.drive(1'b0);
    bound(1'b0, 1'b0);
    check(11'({lvl, fn, busy}), 11'h2);
    tcr(8'h80);
    core.cc_mask = 1'b0;
    bound(1'b0, 1'b0);
    enter(2'h1, isq_pkg::VEC_EXT);
    bound(1'b0, 1'b0);
    enter(2'h2, isq_pkg::VEC_TIMER);
    tcr(8'h40);
    bound(1'b0, 1'b0);
    check(11'({flag, mask, fn}), 11'h3);
    i_isq_irq_src.drive(1'b1);
    i_isq_irq_src.drive(1'b0);
    bound(1'b0, 1'b0);
    enter(2'h1, isq_pkg::VEC_EXT);
    $display("t_hw done");
  endtask : t_hw
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) tick();
    rst = 1'b0;
    repeat (3) tick();
    t_trap();
    t_hw();
    summarize();
  end
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
endmodule : testbench
bind isq_sequencer isq_assertions i_isq_assertions (.clk_sys(clk_sys), .rst(rst),
  .core(core), .entry(entry), .unstack(unstack), .fetch_next(fetch_next), .busy(busy),
  .src_taken(src_taken), .timer_req_flag(timer_req_flag), .timer_req_mask(timer_req_mask));
`default_nettype wire
